/* hdl/tptp_tx_stamp.sv */
// transmit timestamp port: capture, report, one-step insertion, apb status
//
// Contract
// RULE1: normal mode time is 48 bits seconds then 32 bits nanoseconds.
// RULE2: transparent mode: bit 63 sign, 62:16 nanoseconds, 15:0 fraction.
// RULE3: client drives system time on this clock; no resynchronisation here.
// RULE4: stamp valid high while a captured stamp stands on the outputs.
// RULE5: lane index (one of 20) of the frame start goes with each stamp.
// RULE6: tag output equals the tag given with that frame.
// RULE7: stamp equals system time when frame start passed the capture plane.
// RULE8: stamp keeps the bit layout of the system time input.
// RULE9: opcode 00 captures nothing and passes frame; 11 reserved.
// RULE10: opcode 01 captures a stamp and inserts it into the frame.
// RULE11: opcode 10 captures and returns a stamp, frame unaltered.
// RULE12: tag input ignored for no-operation frames.
// RULE13: one-step and two-step stamps come back with their frame tag.
// RULE14: checksum flag ignored unless one-step; 0 means no udp checksum.
// RULE15: checksum flag 1 on one-step: udp checksum recomputed for stamp.
// RULE16: stamp inserted at client byte offset from destination address.
// RULE17: checksum located at the client checksum byte offset.
// RULE18: client gives only even offsets.
// RULE19: tag store write failure sets sticky error until path reset.
// RULE20: stamp valid lasts one cycle with stamp, tag, lane stable.
`timescale 1ns/10ps
module tptp_tx_stamp
  import tptp_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              pce,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [DATA_W-1:0] pwdata,
  output logic      [DATA_W-1:0] prdata,
  output logic                   pready,
  output logic                   pslverr,
  // time and frame side-band
  input  wire logic [TIME_W-1:0] tx_system_time_in,
  input  wire logic [1:0]        tx_frame_stamp_opcode,
  input  wire logic [TAG_W-1:0]  tx_frame_tag,
  input  wire logic              tx_frame_csum_update,
  input  wire logic [OFF_W-1:0]  tx_frame_stamp_byte_offset,
  input  wire logic [OFF_W-1:0]  tx_frame_csum_byte_offset,
  // frame stream in
  input  wire logic              tx_in_valid,
  input  wire logic              tx_in_frame_start,
  input  wire logic              tx_in_frame_end,
  input  wire logic [WORD_W-1:0] tx_in_data,
  input  wire logic [LANE_W-1:0] tx_in_lane,
  // frame stream out
  output logic                   tx_out_valid,
  output logic                   tx_out_frame_start,
  output logic                   tx_out_frame_end,
  output logic      [WORD_W-1:0] tx_out_data,
  // stamp report
  output logic                   tx_stamp_valid,
  output logic      [TIME_W-1:0] tx_stamp_value,
  output logic      [TAG_W-1:0]  tx_stamp_tag_return,
  output logic      [LANE_W-1:0] tx_stamp_lane_index,
  output logic                   tx_stamp_fifo_write_error,
  output logic                   tx_stamp_fifo_read_error
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic              ready_q, slverr_q, tc_mode_q, open_q, wr_err_q, rd_err_q;
  logic [DATA_W-1:0] rdata_q, count_q;
  logic [1:0]        op_q;
  logic              upd_q;
  logic [WIDX_W-1:0] ts_word_q, ck_word_q, widx_q;
  logic [TIME_W-1:0] stamp_q;
  logic              sv_q, ov_q, os_q, oe_q;
  logic [WORD_W-1:0] od_q;
  logic [TAG_W-1:0]  tag_q;
  logic [LANE_W-1:0] lane_q;

  // ----------------------------------------------------------------
  // apb slave: one wait-free access phase
  // ----------------------------------------------------------------
  logic setup, access, wr_ctrl, path_rst, mapped;

  always_comb begin
    setup    = psel & ~penable;
    access   = psel & penable & ready_q;
    mapped   = (paddr == REG_CTRL) | (paddr == REG_STATUS) | (paddr == REG_COUNT);
    wr_ctrl  = access & pwrite & ~slverr_q & (paddr == REG_CTRL);
    path_rst = wr_ctrl & pwdata[CTRL_RST_BIT];
  end

  // ready and error are raised for exactly the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ready_q  <= 1'b0;
      slverr_q <= 1'b0;
    end else if (pce) begin
      ready_q  <= setup;
      slverr_q <= setup & ~mapped;
    end
  end

  // read data latched in setup so it is stable through access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_q <= RESET_WORD;
    end else if (pce && setup) begin
      rdata_q <= RESET_WORD;
      if (!pwrite) begin
        case (paddr)
          REG_CTRL:   rdata_q[CTRL_TC_BIT] <= tc_mode_q;
          REG_STATUS: begin
            rdata_q[ST_WR_ERR] <= wr_err_q;
            rdata_q[ST_RD_ERR] <= rd_err_q;
            rdata_q[ST_OPEN]   <= open_q;
          end
          REG_COUNT:  rdata_q <= count_q;
          default:    rdata_q <= RESET_WORD;
        endcase
      end
    end
  end

  // time format select steers insertion width
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tc_mode_q <= 1'b0;
    end else if (pce && wr_ctrl) begin
      tc_mode_q <= pwdata[CTRL_TC_BIT];  // see RULE2
    end
  end

  // ----------------------------------------------------------------
  // per-frame context: live on the start beat, held afterwards
  // ----------------------------------------------------------------
  logic              beat, sop_beat, take;
  logic [1:0]        cur_op;
  logic              cur_upd;
  logic [WIDX_W-1:0] cur_ts, cur_ck, cur_widx;
  logic [TIME_W-1:0] cur_stamp;

  always_comb begin
    beat      = pce & tx_in_valid;
    sop_beat  = beat & tx_in_frame_start;
    cur_op    = tx_in_frame_start ? tx_frame_stamp_opcode : op_q;
    cur_upd   = tx_in_frame_start ? tx_frame_csum_update : upd_q;
    // byte offsets are even, so bit 0 is dropped; see RULE18
    cur_ts    = tx_in_frame_start ? tx_frame_stamp_byte_offset[OFF_W-1:1] : ts_word_q;  // see RULE16
    cur_ck    = tx_in_frame_start ? tx_frame_csum_byte_offset[OFF_W-1:1] : ck_word_q;   // see RULE17
    cur_widx  = tx_in_frame_start ? '0 : widx_q;
    cur_stamp = tx_in_frame_start ? tx_system_time_in : stamp_q;  // see RULE3
    // reserved opcode is treated like no operation
    take      = sop_beat & ((tx_frame_stamp_opcode == OP_ONE) | (tx_frame_stamp_opcode == OP_TWO));  // see RULE9
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_q      <= OP_NOP;
      upd_q     <= 1'b0;
      ts_word_q <= '0;
      ck_word_q <= '0;
      stamp_q   <= '0;
    end else if (sop_beat) begin
      op_q      <= tx_frame_stamp_opcode;
      upd_q     <= tx_frame_csum_update;
      ts_word_q <= tx_frame_stamp_byte_offset[OFF_W-1:1];
      ck_word_q <= tx_frame_csum_byte_offset[OFF_W-1:1];
      stamp_q   <= tx_system_time_in;  // see RULE7
    end
  end

  // word position within the frame
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      widx_q <= '0;
    end else if (beat) begin
      widx_q <= cur_widx + WIDX_W'(1);
    end
  end

  // ----------------------------------------------------------------
  // stamp words and incremental checksum
  // ----------------------------------------------------------------
  logic [WORD_W-1:0] sw [NORM_WORDS];
  logic [WORD_W-1:0] acc [NORM_WORDS];
  logic [WORD_W-1:0] ck_fold;

  // normal: 80 bits as five words; transparent: low 64 bits as four
  always_comb begin
    for (int i = 0; i < NORM_WORDS; i++) begin
      if (!tc_mode_q) begin
        sw[i] = cur_stamp[TIME_W-1-WORD_W*i -: WORD_W];  // see RULE1
      end else if (i < TC_WORDS) begin
        sw[i] = cur_stamp[TC_TOP_BIT-WORD_W*i -: WORD_W];  // see RULE2
      end else begin
        sw[i] = '0;
      end
    end
  end

  assign acc[0] = sw[0];
  // sum of inserted words, assuming the client zeroed the field
  for (genvar g = 1; g < NORM_WORDS; g++) begin : g_sum
    tptp_oc_add u_add (
      .a   (acc[g-1]),
      .b   (sw[g]),
      .sum (acc[g])
    );
  end

  tptp_oc_add u_fold (
    .a   (~tx_in_data),
    .b   (acc[NORM_WORDS-1]),
    .sum (ck_fold)
  );

  // ----------------------------------------------------------------
  // one-step rewrite of the stream
  // ----------------------------------------------------------------
  logic [WIDX_W-1:0] k;
  logic              ins_hit, ck_hit;
  logic [WORD_W-1:0] out_word;

  always_comb begin
    k        = cur_widx - cur_ts;
    ins_hit  = (cur_op == OP_ONE) & (cur_widx >= cur_ts) &
               (k < (tc_mode_q ? WIDX_W'(TC_WORDS) : WIDX_W'(NORM_WORDS)));  // see RULE10
    ck_hit   = (cur_op == OP_ONE) & cur_upd & (cur_widx == cur_ck) & ~ins_hit;  // see RULE14
    out_word = tx_in_data;  // see RULE11
    if (ins_hit) begin
      out_word = sw[k[KSEL_W-1:0]];  // see RULE16
    end else if (ck_hit) begin
      out_word = ~ck_fold;  // see RULE15
    end
  end

  // one register stage on the stream
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ov_q <= 1'b0;
      os_q <= 1'b0;
      oe_q <= 1'b0;
      od_q <= '0;
    end else if (pce) begin
      ov_q <= tx_in_valid;
      os_q <= tx_in_valid & tx_in_frame_start;
      oe_q <= tx_in_valid & tx_in_frame_end;
      od_q <= tx_in_valid ? out_word : od_q;
    end
  end

  // ----------------------------------------------------------------
  // stamp report: one cycle per captured frame
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sv_q <= 1'b0;
    end else if (pce) begin
      sv_q <= take;  // see RULE4, RULE20
    end
  end

  // tag ignored for no-operation frames: fields only load on capture
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tag_q   <= '0;
      lane_q  <= '0;
      count_q <= RESET_WORD;
    end else if (take) begin
      tag_q   <= tx_frame_tag;  // see RULE6, RULE12, RULE13
      lane_q  <= tx_in_lane;    // see RULE5
      count_q <= count_q + DATA_W'(1);
    end
  end

  // ----------------------------------------------------------------
  // tag store occupancy and sticky errors
  // ----------------------------------------------------------------
  // a start while a frame is open overwrites the tag: write error
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      open_q   <= 1'b0;
      wr_err_q <= 1'b0;
      rd_err_q <= 1'b0;
    end else if (pce) begin
      if (path_rst) begin
        open_q <= 1'b0;
      end else if (beat) begin
        open_q <= tx_in_frame_start ? ~tx_in_frame_end : (open_q & ~tx_in_frame_end);
      end
      // set wins over the path reset clear
      wr_err_q <= (wr_err_q & ~path_rst) | (sop_beat & open_q);  // see RULE19
      rd_err_q <= (rd_err_q & ~path_rst) | (beat & tx_in_frame_end & ~tx_in_frame_start & ~open_q);
    end
  end

  assign prdata                    = rdata_q;
  assign pready                    = ready_q;
  assign pslverr                   = slverr_q;
  assign tx_out_valid              = ov_q;
  assign tx_out_frame_start        = os_q;
  assign tx_out_frame_end          = oe_q;
  assign tx_out_data               = od_q;
  assign tx_stamp_valid            = sv_q;
  assign tx_stamp_value            = stamp_q;  // see RULE8
  assign tx_stamp_tag_return       = tag_q;
  assign tx_stamp_lane_index       = lane_q;
  assign tx_stamp_fifo_write_error = wr_err_q;
  assign tx_stamp_fifo_read_error  = rd_err_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_valid_cause: assert property (@(posedge pclk) disable iff (!presetn) // see RULE4
    tx_stamp_valid && $past(pce) |-> $past(take)) else $error("stamp valid without capture");
  a_valid_single: assert property (@(posedge pclk) disable iff (!presetn) // see RULE20
    pce && tx_stamp_valid && !take |=> !tx_stamp_valid) else $error("stamp valid longer than one cycle");
  a_stamp_time: assert property (@(posedge pclk) disable iff (!presetn) // see RULE7
    take |=> tx_stamp_valid && tx_stamp_value == $past(tx_system_time_in)) else $error("stamp not start time");
  a_tag_return: assert property (@(posedge pclk) disable iff (!presetn) // see RULE13
    take |=> tx_stamp_tag_return == $past(tx_frame_tag)) else $error("tag mismatch");
  a_lane_index: assert property (@(posedge pclk) disable iff (!presetn) // see RULE5
    take |=> tx_stamp_lane_index == $past(tx_in_lane)) else $error("lane mismatch");
  a_noop_quiet: assert property (@(posedge pclk) disable iff (!presetn) // see RULE9
    sop_beat && tx_frame_stamp_opcode == OP_NOP |=> !tx_stamp_valid) else $error("no-op frame stamped");
  a_onestep_first: assert property (@(posedge pclk) disable iff (!presetn) // see RULE10
    sop_beat && tx_frame_stamp_opcode == OP_ONE && tx_frame_stamp_byte_offset == '0 && !tc_mode_q
    |=> tx_out_data == $past(tx_system_time_in[TIME_W-1 -: WORD_W])) else $error("stamp not inserted");
  a_twostep_pass: assert property (@(posedge pclk) disable iff (!presetn) // see RULE11
    beat && cur_op == OP_TWO |=> tx_out_data == $past(tx_in_data)) else $error("two-step frame altered");
  a_nocsum_pass: assert property (@(posedge pclk) disable iff (!presetn) // see RULE14
    beat && cur_op == OP_ONE && !cur_upd && !ins_hit |=> tx_out_data == $past(tx_in_data))
    else $error("checksum touched without flag");
  a_err_sticky: assert property (@(posedge pclk) disable iff (!presetn) // see RULE19
    wr_err_q && !path_rst |=> wr_err_q) else $error("write error dropped");

  c_two_step: cover property (@(posedge pclk) take && tx_frame_stamp_opcode == OP_TWO);
  c_one_csum: cover property (@(posedge pclk) beat && ck_hit);
  c_wr_err:   cover property (@(posedge pclk) sop_beat && open_q);
endmodule

/* pkg/tptp_pkg.sv */
// constants shared by the transmit timestamp port
package tptp_pkg;
  // ----------------------------------------------------------------
  // time formats
  // ----------------------------------------------------------------
  localparam int TIME_W      = 80;  // system time and stamp width
  localparam int SEC_W       = 48;  // normal mode seconds field
  localparam int NS_W        = 32;  // normal mode nanoseconds field
  localparam int TC_SIGN_BIT = 63;  // transparent mode sign bit
  localparam int TC_NS_LO    = 16;  // transparent mode ns field 62:16
  localparam int TC_FRAC_HI  = 15;  // transparent mode fraction 15:0
  localparam int TC_TOP_BIT  = 63;  // top bit inserted in transparent mode

  // ----------------------------------------------------------------
  // frame side-band and stream
  // ----------------------------------------------------------------
  localparam int LANE_W     = 5;   // lane index width
  localparam int LANE_COUNT = 20;  // lanes a frame start may land on
  localparam int TAG_W      = 16;
  localparam int WORD_W     = 16;  // two bytes per beat
  localparam int OFF_W      = 16;  // byte offsets
  localparam int WIDX_W     = 15;  // word index inside a frame
  localparam int NORM_WORDS = 5;   // 80-bit stamp as 16-bit words
  localparam int TC_WORDS   = 4;   // 64-bit stamp as 16-bit words
  localparam int KSEL_W     = 3;

  localparam logic [1:0] OP_NOP  = 2'h0;
  localparam logic [1:0] OP_ONE  = 2'h1;
  localparam logic [1:0] OP_TWO  = 2'h2;
  localparam logic [1:0] OP_RSVD = 2'h3;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int          ADDR_W       = 12;
  localparam int          DATA_W       = 32;
  localparam logic [11:0] REG_CTRL     = 12'h000;
  localparam logic [11:0] REG_STATUS   = 12'h004;
  localparam logic [11:0] REG_COUNT    = 12'h008;
  localparam int          CTRL_TC_BIT  = 0;  // transparent clock mode
  localparam int          CTRL_RST_BIT = 1;  // write 1: transmit path reset
  localparam int          ST_WR_ERR    = 0;
  localparam int          ST_RD_ERR    = 1;
  localparam int          ST_OPEN      = 2;
  localparam logic [31:0] RESET_WORD   = 32'h0000_0000;
endpackage

/* hdl/tptp_oc_add.sv */
// ones-complement 16-bit adder with end-around carry
`timescale 1ns/10ps
module tptp_oc_add
  import tptp_pkg::*;
(
  input  wire logic [WORD_W-1:0] a,
  input  wire logic [WORD_W-1:0] b,
  output logic      [WORD_W-1:0] sum
);
  logic [WORD_W:0] raw;

  // carry folds back into bit 0, as checksum arithmetic needs
  always_comb begin
    raw = {1'b0, a} + {1'b0, b};
    sum = raw[WORD_W-1:0] + {{(WORD_W-1){1'b0}}, raw[WORD_W]};
  end
endmodule

/* dv/tptp_client_model.sv */
// client model: system time source and frame sender for the stamp port
`timescale 1ns/10ps
module tptp_client_model
  import tptp_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  output logic      [TIME_W-1:0] tx_system_time_in,
  output logic      [1:0]        tx_frame_stamp_opcode,
  output logic      [TAG_W-1:0]  tx_frame_tag,
  output logic                   tx_frame_csum_update,
  output logic      [OFF_W-1:0]  tx_frame_stamp_byte_offset,
  output logic      [OFF_W-1:0]  tx_frame_csum_byte_offset,
  output logic                   tx_in_valid,
  output logic                   tx_in_frame_start,
  output logic                   tx_in_frame_end,
  output logic      [WORD_W-1:0] tx_in_data,
  output logic      [LANE_W-1:0] tx_in_lane
);
  // ----------------------------------------------------------------
  // system time
  // ----------------------------------------------------------------
  // runs on pclk itself, so nothing downstream has to cross domains
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_system_time_in <= 80'h0000_0001_00A5_1234_0000;
    end else begin
      tx_system_time_in <= tx_system_time_in + 80'h32;
    end
  end

  // ----------------------------------------------------------------
  // frame sender
  // ----------------------------------------------------------------
  initial begin
    {tx_in_valid, tx_in_frame_start, tx_in_frame_end, tx_in_data, tx_in_lane} = '0;
    {tx_frame_stamp_opcode, tx_frame_tag, tx_frame_csum_update} = '0;
    {tx_frame_stamp_byte_offset, tx_frame_csum_byte_offset} = '0;
  end

  // one frame of n words; no_end leaves the frame open on purpose
  task automatic send(input logic [1:0] op, input logic [15:0] tag, input logic cs, input int ts,
                      input logic [4:0] ln, input int n, input logic [15:0] sd, input bit no_end);
    for (int i = 0; i < n; i++) begin
      @(posedge pclk);
      tx_in_valid       <= 1'b1;
      tx_in_frame_start <= (i == 0);
      tx_in_frame_end   <= (i == n - 1) && !no_end;
      // stamp field left zero, the checksum fix-up relies on it
      tx_in_data <= (op == OP_ONE && i >= ts / 2 && i < ts / 2 + 5) ? 16'h0000 : sd ^ 16'(i * 257);
      if (i == 0) begin
        tx_frame_stamp_opcode      <= op;
        tx_frame_tag               <= tag;
        tx_frame_csum_update       <= cs;
        tx_frame_stamp_byte_offset <= 16'(ts & ~1);
        tx_frame_csum_byte_offset  <= 16'((ts + 14) & ~1);
        tx_in_lane                 <= ln;
      end else begin
        // side-band is stale after the start beat, so it must not look valid
        {tx_frame_tag, tx_frame_csum_update, tx_in_lane} <= ~{tx_frame_tag, tx_frame_csum_update, tx_in_lane};
        {tx_frame_stamp_byte_offset, tx_frame_csum_byte_offset} <=
          ~{tx_frame_stamp_byte_offset, tx_frame_csum_byte_offset};
      end
    end
    @(posedge pclk);
    {tx_in_valid, tx_in_frame_start, tx_in_frame_end} <= 3'h0;
    tx_in_data <= ~tx_in_data;
  endtask
endmodule

/* dv/tx_ptp_timestamp_port_bench.sv */
// self-checking bench for the transmit timestamp port
`timescale 1ns/10ps
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin err_count++; \
  $display("ERROR %0t got %h exp %h", $time, got, exp); end end
module tx_ptp_timestamp_port_bench
  import tptp_pkg::*;
;
  logic              pclk = 1'b0;
  logic              ce = 1'b1;
  logic              presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0]       paddr;
  logic [31:0]       pwdata, prdata;
  logic [TIME_W-1:0] sys_time, tx_stamp_value, f_tm;
  logic [1:0]        op_in, f_op;
  logic [15:0]       tag_in, tso, cso, din, dout, tx_stamp_tag_return, lt_tag;
  logic              cs_in, vin, sin, ein, vout, sout, eout, tx_stamp_valid, wr_err, f_cs, f_tc, tc;
  logic [4:0]        lane_in, tx_stamp_lane_index;
  logic [17:0]       q_w[$];
  logic [79:0]       q_ts[$];
  logic [15:0]       q_tag[$];
  logic [4:0]        q_ln[$];
  logic [31:0]       rnd = 32'h4F5C4593;
  int                err_count = 0, checks_done = 0, stamps = 0, f_ts, f_co, w_i;

  always #25 pclk = ~pclk;

  // ----------------------------------------------------------------
  // design and client
  // ----------------------------------------------------------------
  tptp_tx_stamp dut (.pclk(pclk), .presetn(presetn), .pce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tx_system_time_in(sys_time), .tx_frame_stamp_opcode(op_in), .tx_frame_tag(tag_in),
    .tx_frame_csum_update(cs_in), .tx_frame_stamp_byte_offset(tso), .tx_frame_csum_byte_offset(cso),
    .tx_in_valid(vin), .tx_in_frame_start(sin), .tx_in_frame_end(ein), .tx_in_data(din),
    .tx_in_lane(lane_in), .tx_out_valid(vout), .tx_out_frame_start(sout), .tx_out_frame_end(eout),
    .tx_out_data(dout), .tx_stamp_valid(tx_stamp_valid), .tx_stamp_value(tx_stamp_value),
    .tx_stamp_tag_return(tx_stamp_tag_return), .tx_stamp_lane_index(tx_stamp_lane_index),
    .tx_stamp_fifo_write_error(wr_err), .tx_stamp_fifo_read_error());
  tptp_client_model cl (.pclk(pclk), .presetn(presetn), .tx_system_time_in(sys_time),
    .tx_frame_stamp_opcode(op_in), .tx_frame_tag(tag_in), .tx_frame_csum_update(cs_in),
    .tx_frame_stamp_byte_offset(tso), .tx_frame_csum_byte_offset(cso), .tx_in_valid(vin),
    .tx_in_frame_start(sin), .tx_in_frame_end(ein), .tx_in_data(din), .tx_in_lane(lane_in));

  // ----------------------------------------------------------------
  // reference model
  // ----------------------------------------------------------------
  // one-step rewrite of one word: stamp first, else checksum fix-up
  function automatic logic [15:0] xform(input logic [15:0] d, input int w);
    int k;
    logic [16:0] s;
    k = f_tc ? TC_WORDS : NORM_WORDS;
    if (f_op != OP_ONE) return d;
    if (w >= f_ts / 2 && w < f_ts / 2 + k) return f_tm[16 * (k - 1 - (w - f_ts / 2)) +: 16];
    if (!f_cs || w != f_co / 2) return d;
    s = {1'b0, ~d};
    for (int j = 0; j < k; j++) begin
      s = s[15:0] + f_tm[16 * j +: 16];
      s = s[15:0] + s[16];
    end
    return ~s[15:0];
  endfunction

  // outputs seen at an edge belong to inputs pushed at the edge before
  always @(posedge pclk) begin
    logic [17:0] ew;
    logic [79:0] et;
    logic [4:0]  el;
    if (presetn === 1'b1) begin
      if (vout === 1'b1) begin
        `CHK(q_w.size() > 0, 1'b1)
        ew = q_w.pop_front();
        `CHK({sout, eout, dout}, ew)
      end
      if (tx_stamp_valid === 1'b1) begin
        `CHK(q_ts.size() > 0, 1'b1)
        et = q_ts.pop_front();
        `CHK(tx_stamp_value, et)
        lt_tag = q_tag.pop_front();
        `CHK(tx_stamp_tag_return, lt_tag)
        el = q_ln.pop_front();
        `CHK(tx_stamp_lane_index, el)
      end
      // beats offered while the enable is low are not taken
      if (vin === 1'b1 && ce === 1'b1) begin
        if (sin === 1'b1) begin
          {f_op, f_cs, f_tm, f_tc, w_i} = {op_in, cs_in, sys_time, tc, 32'h0};
          f_ts = tso;
          f_co = cso;
          if (f_op == OP_ONE || f_op == OP_TWO) begin
            q_ts.push_back(sys_time);
            q_tag.push_back(tag_in);
            q_ln.push_back(lane_in);
            stamps++;
          end
        end
        q_w.push_back({sin, ein, xform(din, w_i)});
        w_i++;
      end
    end
  end

  // ----------------------------------------------------------------
  // stimulus helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] rand32();
    rnd = {rnd[30:0], rnd[31] ^ rnd[21] ^ rnd[1] ^ rnd[0]};
    return rnd;
  endfunction

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    // only the watchdog ends a wait for the answer
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    {psel, penable} <= 2'b00;
  endtask

  task automatic frame(input logic [1:0] op, input logic cs);
    logic [31:0] x;
    x = rand32();
    cl.send(op, x[15:0], cs, 2 * int'(x[17:16]), 5'(x[31:24] % LANE_COUNT), 12, x[31:16], 1'b0);
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // watchdog: the sequence needs well under two thousand cycles
  initial begin
    repeat (5000) @(posedge pclk);
    err_count++;
    stop_test;
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] r;
    logic e;
    {presetn, psel, penable, pwrite, paddr, pwdata, tc} = '0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    `CHK({tx_stamp_valid, wr_err, tx_stamp_value}, 82'h0)
    for (int a = 0; a < 3; a++) begin
      apb(1'b0, 12'(a * 4), 32'h0, r, e);
      `CHK(r, RESET_WORD)
    end
    $display("test reset done");
    // every legal code, normal then transparent layout
    for (int m = 0; m < 2; m++) begin
      apb(1'b1, REG_CTRL, 32'(m), r, e);
      tc = m[0];
      for (int op = 0; op < 3; op++) frame(2'(op), 1'b0);
      frame(OP_ONE, 1'b1);
      frame(OP_TWO, 1'b1);
      // stamp at offset zero, top lane, checksum fixed up
      cl.send(OP_ONE, 16'h1234, 1'b1, 0, 5'h13, 12, 16'h0F0F, 1'b0);
      frame(OP_NOP, 1'b1);
      repeat (2) @(posedge pclk);
      `CHK(tx_stamp_tag_return, lt_tag)
      $display("test stamp modes %0d done", m);
    end
    // frame left open, then a new start: sticky error until path reset
    cl.send(OP_NOP, 16'h0, 1'b0, 0, 5'h0, 4, 16'h5A5A, 1'b1);
    cl.send(OP_NOP, 16'h0, 1'b0, 0, 5'h0, 4, 16'hA5A5, 1'b0);
    repeat (4) @(posedge pclk);
    `CHK(wr_err, 1'b1)
    apb(1'b0, REG_STATUS, 32'h0, r, e);
    `CHK(r[2:0], 3'b001)
    apb(1'b1, REG_CTRL, 32'h2, r, e);
    tc = 1'b0;
    @(posedge pclk);
    `CHK(wr_err, 1'b0)
    $display("test sticky error done");
    // a frame offered while frozen must leave no stamp and no count
    ce <= 1'b0;
    frame(OP_TWO, 1'b0);
    ce <= 1'b1;
    `CHK(tx_stamp_valid, 1'b0)
    apb(1'b0, REG_COUNT, 32'h0, r, e);
    `CHK({e, r}, {1'b0, 32'(stamps)})
    apb(1'b1, REG_STATUS, 32'hFFFF_FFFF, r, e);
    apb(1'b0, REG_STATUS, 32'h0, r, e);
    `CHK(r, 32'h0)
    apb(1'b0, 12'h00C, 32'h0, r, e);
    `CHK({e, r}, 33'h1_0000_0000)
    apb(1'b0, REG_CTRL, 32'h0, r, e);
    `CHK(r, 32'h0)
    $display("test registers done");
    repeat (3) @(posedge pclk);
    `CHK(q_w.size() + q_ts.size(), 0)
    stop_test;
  end
endmodule
